// file: shared/acc_pkg.sv
// Constants for the converter input and conversion control block
package acc_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTRL_ZERO  = 8'h00;
	localparam logic [7:0] OFS_CTRL_ONE   = 8'h04;
	localparam logic [7:0] OFS_RES_HIGH   = 8'h08;
	localparam logic [7:0] OFS_RES_LOW    = 8'h0c;
	localparam logic [7:0] OFS_FSEL_LOW   = 8'h10;
	localparam logic [7:0] OFS_FSEL_HIGH  = 8'h14;
	localparam logic [7:0] OFS_PULLUP     = 8'h18;
	localparam logic [7:0] OFS_PORT_DIR   = 8'h1c;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CZ_START_BIT  = 7;
	localparam int CZ_BUSY_BIT   = 6;
	localparam int CZ_POWER_BIT  = 5;
	localparam int CZ_FORMAT_BIT = 4;
	localparam int CZ_CHAN_LSB   = 0;
	localparam int CO_SRC_LSB    = 4;
	localparam int CO_DIV_LSB    = 0;

	// ************************************************************
	// Widths, reset values and timing counts
	// ************************************************************
	localparam int CHAN_W     = 4;
	localparam int SRC_W      = 4;
	localparam int DIV_SEL_W  = 3;
	localparam int RES_W      = 12;
	localparam int NUM_PINS   = 8;
	localparam int NUM_INT    = 6;
	localparam int SAMPLE_CLKS  = 4;
	localparam int CONVERT_CLKS = 12;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ************************************************************
	// Source select codes
	// ************************************************************
	localparam logic [1:0] SRC_GROUP_GND = 2'h2;
	localparam logic [1:0] SRC_GROUP_EXT = 2'h3;
	localparam logic [1:0] SRC_SUB_EXT   = 2'h0;
	localparam logic [2:0] SRC_INT_STEP  = 3'h3;

	// Pin function code that makes a pin an analog input
	localparam logic [1:0] FSEL_ANALOG = 2'h3;

	// External channel code served by each implemented pin
	localparam logic [CHAN_W-1:0] CHAN_CODE [NUM_PINS] = '{
		4'h0, 4'h1, 4'h2, 4'h4, 4'hb, 4'hd, 4'he, 4'hf
	};

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h1,
		ST_SAMPLE  = 3'h2,
		ST_CONVERT = 3'h4
	} acc_state_t;

endpackage

// file: shared/acc_clk_if.sv
// Link between the control logic and the conversion clock divider
`timescale 1ns/10ps
interface acc_clk_if;
	logic       run;
	logic [2:0] div_sel;
	logic       tick;
	modport ctrl (output run, output div_sel, input tick);
	modport div  (input run, input div_sel, output tick);
endinterface

// file: src/acc_clk_div.sv
// Conversion clock divider: one tick every 2**div_sel system clocks
`timescale 1ns/10ps
module acc_clk_div #(
	parameter int DIV_W = 7
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic ce_i,
	acc_clk_if.div    clk_if
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W:0]   lim_wide;
	logic [DIV_W-1:0] lim;

	generate
		if (DIV_W < (2 ** acc_pkg::DIV_SEL_W) - 1) begin : g_chk
			$error("acc_clk_div: DIV_W too small for divider field");
		end
	endgenerate

	always_comb begin
		lim_wide = ((DIV_W+1)'(1) << clk_if.div_sel) - (DIV_W+1)'(1);
		lim = lim_wide[DIV_W-1:0];
	end

	assign clk_if.tick = clk_if.run & (cnt_q == lim);

	// ************************************************************
	// Period counter, held at zero while no conversion runs
	// ************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			if (!clk_if.run || cnt_q == lim) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + DIV_W'(1);
			end
		end
	end
endmodule

// file: src/acc_ctrl.sv
// Converter input routing, start, timing and result control with APB
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
//
// Contract
// - Pin set to analog input loses its digital or alternate function.
// - Pull-up on an analog input pin is disconnected automatically.
// - Analog input selection overrides the port direction setting.
// - Source codes 0000, 0100, 11xx route the selected external channel.
// - Codes 0001-0011 route supply fractions; 0101-0111 amplifier fractions.
// - Source codes 10xx connect the converter input to ground.
// - Internal source selected disconnects every external channel.
// - Start bit written high then low begins one conversion.
// - Busy flag set when conversion starts, cleared when it completes.
// - Completion raises the converter interrupt request.
// - Conversion clock is system clock divided by 2**divider field.
// - Converter circuitry powered only while enable bit is high.
// - Conversion lasts 16 clocks: 4 sampling then 12 converting.
// - Format bit selects 8/4 or 4/8 split of the result.
// - Clearing enable leaves both result registers unchanged.
module acc_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic                           ref_clk_i,
	input  wire logic                           nrst_i,
	input  wire logic                           ce_i,
	input  wire logic                           psel_i,
	input  wire logic                           penable_i,
	input  wire logic                           pwrite_i,
	input  wire logic [ADDR_W-1:0]              paddr_i,
	input  wire logic [31:0]                    pwdata_i,
	output logic      [31:0]                    prdata_o,
	output logic                                pready_o,
	output logic                                pslverr_o,
	input  wire logic                           comp_hi_i,
	output logic      [acc_pkg::RES_W-1:0]      dac_code_o,
	output logic                                sample_o,
	output logic                                power_en_o,
	output logic      [acc_pkg::NUM_PINS-1:0]   ext_chan_en_o,
	output logic      [acc_pkg::NUM_INT-1:0]    int_src_sel_o,
	output logic                                gnd_sel_o,
	output logic                                conv_done_o,
	output logic      [acc_pkg::NUM_PINS-1:0]   pin_analog_o,
	output logic      [acc_pkg::NUM_PINS-1:0]   pin_dig_en_o,
	output logic      [acc_pkg::NUM_PINS-1:0]   pin_pullup_o,
	output logic      [acc_pkg::NUM_PINS-1:0]   pin_drive_o
);
	localparam int NP = acc_pkg::NUM_PINS;
	localparam int RW = acc_pkg::RES_W;

	generate
		if (ADDR_W < 8) begin : g_chk
			$error("acc_ctrl: ADDR_W must be at least 8");
		end
	endgenerate

	// ************************************************************
	// Register state
	// ************************************************************
	logic                          start_q;
	logic                          power_q;
	logic                          format_q;
	logic [acc_pkg::CHAN_W-1:0]    chan_q;
	logic [acc_pkg::SRC_W-1:0]     src_q;
	logic [acc_pkg::DIV_SEL_W-1:0] div_q;
	logic [NP-1:0]                 fsel_lo_q;
	logic [NP-1:0]                 fsel_hi_q;
	logic [NP-1:0]                 pullup_q;
	logic [NP-1:0]                 dir_q;
	logic [RW-1:0]                 result_q;
	logic                          busy_q;
	logic [31:0]                   prdata_q;
	logic                          done_q;

	// Conversion sequencer state
	acc_pkg::acc_state_t           state_q;
	logic [3:0]                    cnt_q;
	logic [RW-1:0]                 sar_q;

	// Routing outputs held in flops
	logic [NP-1:0]                 ext_en_q;
	logic [acc_pkg::NUM_INT-1:0]   int_sel_q;
	logic                          gnd_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic       setup_ph;
	logic       access_ph;
	logic       wr_en;
	logic [7:0] addr;
	logic       hit;
	logic       launch;
	logic [7:0] wbyte;

	assign addr      = paddr_i[7:0];
	assign wbyte     = pwdata_i[7:0];
	assign setup_ph  = psel_i & ~penable_i;
	assign access_ph = psel_i & penable_i;
	assign pready_o  = ce_i;
	assign wr_en     = access_ph & pwrite_i & ce_i & hit;

	always_comb begin
		hit = 1'b0;
		// Upper address bits must be clear to hit
		if ((paddr_i >> 8) == '0) begin
			unique case (addr)
				acc_pkg::OFS_CTRL_ZERO,
				acc_pkg::OFS_CTRL_ONE,
				acc_pkg::OFS_RES_HIGH,
				acc_pkg::OFS_RES_LOW,
				acc_pkg::OFS_FSEL_LOW,
				acc_pkg::OFS_FSEL_HIGH,
				acc_pkg::OFS_PULLUP,
				acc_pkg::OFS_PORT_DIR: hit = 1'b1;
				default:               hit = 1'b0;
			endcase
		end
	end

	assign pslverr_o = access_ph & ~hit;

	// Falling write of the start bit, after it was high
	assign launch = wr_en & hit & (addr == acc_pkg::OFS_CTRL_ZERO) &
		start_q & ~wbyte[acc_pkg::CZ_START_BIT];

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			start_q   <= 1'b0;
			power_q   <= 1'b0;
			format_q  <= 1'b0;
			chan_q    <= '0;
		end else if (wr_en && addr == acc_pkg::OFS_CTRL_ZERO) begin
			start_q  <= wbyte[acc_pkg::CZ_START_BIT];
			power_q  <= wbyte[acc_pkg::CZ_POWER_BIT];
			format_q <= wbyte[acc_pkg::CZ_FORMAT_BIT];
			chan_q   <= wbyte[acc_pkg::CZ_CHAN_LSB +: acc_pkg::CHAN_W];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			src_q <= '0;
			div_q <= '0;
		end else if (wr_en && addr == acc_pkg::OFS_CTRL_ONE) begin
			src_q <= wbyte[acc_pkg::CO_SRC_LSB +: acc_pkg::SRC_W];
			div_q <= wbyte[acc_pkg::CO_DIV_LSB +: acc_pkg::DIV_SEL_W];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			fsel_lo_q <= acc_pkg::REG_RESET;
			fsel_hi_q <= acc_pkg::REG_RESET;
			pullup_q  <= acc_pkg::REG_RESET;
			dir_q     <= acc_pkg::REG_RESET;
		end else if (wr_en) begin
			if (addr == acc_pkg::OFS_FSEL_LOW) begin
				fsel_lo_q <= wbyte;
			end
			if (addr == acc_pkg::OFS_FSEL_HIGH) begin
				fsel_hi_q <= wbyte;
			end
			if (addr == acc_pkg::OFS_PULLUP) begin
				pullup_q <= wbyte;
			end
			if (addr == acc_pkg::OFS_PORT_DIR) begin
				dir_q <= wbyte;
			end
		end
	end

	// ************************************************************
	// Read data, captured in the setup cycle
	// ************************************************************
	logic [7:0] rbyte;
	logic [7:0] res_hi;
	logic [7:0] res_lo;

	always_comb begin
		if (format_q) begin
			res_hi = {4'h0, result_q[11:8]};
			res_lo = result_q[7:0];
		end else begin
			res_hi = result_q[11:4];
			res_lo = {result_q[3:0], 4'h0};
		end
	end

	always_comb begin
		rbyte = 8'h00;
		unique case (addr)
			acc_pkg::OFS_CTRL_ZERO: begin
				rbyte[acc_pkg::CZ_START_BIT]  = start_q;
				rbyte[acc_pkg::CZ_BUSY_BIT]   = busy_q;
				rbyte[acc_pkg::CZ_POWER_BIT]  = power_q;
				rbyte[acc_pkg::CZ_FORMAT_BIT] = format_q;
				rbyte[acc_pkg::CZ_CHAN_LSB +: acc_pkg::CHAN_W] = chan_q;
			end
			acc_pkg::OFS_CTRL_ONE: begin
				rbyte[acc_pkg::CO_SRC_LSB +: acc_pkg::SRC_W] = src_q;
				rbyte[acc_pkg::CO_DIV_LSB +: acc_pkg::DIV_SEL_W] = div_q;
			end
			acc_pkg::OFS_RES_HIGH:  rbyte = res_hi;
			acc_pkg::OFS_RES_LOW:   rbyte = res_lo;
			acc_pkg::OFS_FSEL_LOW:  rbyte = fsel_lo_q;
			acc_pkg::OFS_FSEL_HIGH: rbyte = fsel_hi_q;
			acc_pkg::OFS_PULLUP:    rbyte = pullup_q;
			acc_pkg::OFS_PORT_DIR:  rbyte = dir_q;
			default:                rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			prdata_q <= '0;
		end else if (ce_i && setup_ph) begin
			prdata_q <= hit ? {24'h000000, rbyte} : 32'h00000000;
		end
	end

	assign prdata_o = prdata_q;

	// ************************************************************
	// Conversion clock divider
	// ************************************************************
	acc_clk_if clk_if ();

	assign clk_if.run     = (state_q != acc_pkg::ST_IDLE);
	assign clk_if.div_sel = div_q;

	acc_clk_div #(
		.DIV_W (7)
	) u_div (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.clk_if    (clk_if)
	);

	// ************************************************************
	// Conversion sequencer: sampling then one bit per clock
	// ************************************************************
	logic          abort;
	logic          last_bit;
	logic [RW-1:0] decided;
	logic [3:0]    bit_idx;

	// High start bit or power off holds the sequencer in reset
	assign abort    = ~power_q | start_q;
	assign bit_idx  = 4'(RW - 1) - cnt_q;
	assign last_bit = (cnt_q == 4'(acc_pkg::CONVERT_CLKS - 1));

	always_comb begin
		decided = sar_q;
		if (!comp_hi_i) begin
			decided[bit_idx] = 1'b0;
		end
		if (!last_bit) begin
			decided[bit_idx - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_q <= acc_pkg::ST_IDLE;
			cnt_q   <= '0;
			sar_q   <= '0;
		end else if (ce_i) begin
			unique case (state_q)
				acc_pkg::ST_IDLE: begin
					cnt_q <= '0;
					if (launch && power_q) begin
						state_q <= acc_pkg::ST_SAMPLE;
					end
				end
				acc_pkg::ST_SAMPLE: begin
					if (abort) begin
						state_q <= acc_pkg::ST_IDLE;
					end else if (clk_if.tick) begin
						if (cnt_q == 4'(acc_pkg::SAMPLE_CLKS - 1)) begin
							state_q <= acc_pkg::ST_CONVERT;
							cnt_q   <= '0;
							sar_q   <= {1'b1, {(RW-1){1'b0}}};
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				acc_pkg::ST_CONVERT: begin
					if (abort) begin
						state_q <= acc_pkg::ST_IDLE;
					end else if (clk_if.tick) begin
						sar_q <= decided;
						cnt_q <= cnt_q + 4'h1;
						if (last_bit) begin
							state_q <= acc_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= acc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	logic finish;
	assign finish = (state_q == acc_pkg::ST_CONVERT) & ~abort &
		clk_if.tick & last_bit;

	// Result only moves on a finished conversion
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			result_q <= '0;
		end else if (ce_i && finish) begin
			result_q <= decided;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce_i) begin
			busy_q <= (state_q == acc_pkg::ST_IDLE) ? (launch & power_q) :
				~(abort | finish);
			done_q <= finish;
		end
	end

	assign conv_done_o = done_q;
	assign dac_code_o  = sar_q;
	assign sample_o    = (state_q == acc_pkg::ST_SAMPLE);
	assign power_en_o  = power_q;

	// ************************************************************
	// Input source routing
	// ************************************************************
	logic [NP-1:0]               ext_en_d;
	logic [acc_pkg::NUM_INT-1:0] int_sel_d;
	logic                        gnd_d;
	logic                        is_ext;
	logic [2:0]                  int_idx;

	always_comb begin
		is_ext    = 1'b0;
		gnd_d     = 1'b0;
		int_sel_d = '0;
		int_idx   = 3'h0;
		unique case (src_q[3:2])
			acc_pkg::SRC_GROUP_EXT: is_ext = 1'b1;
			acc_pkg::SRC_GROUP_GND: gnd_d = power_q;
			default: begin
				if (src_q[1:0] == acc_pkg::SRC_SUB_EXT) begin
					is_ext = 1'b1;
				end else begin
					int_idx = (src_q[2] ? acc_pkg::SRC_INT_STEP : 3'h0) +
						{1'b0, src_q[1:0]} - 3'h1;
					int_sel_d[int_idx] = power_q;
				end
			end
		endcase
	end

	// External channels connect only for an external source
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			ext_en_d[i] = power_q & is_ext &
				(chan_q == acc_pkg::CHAN_CODE[i]);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			ext_en_q  <= '0;
			int_sel_q <= '0;
			gnd_q     <= 1'b0;
		end else if (ce_i) begin
			ext_en_q  <= ext_en_d;
			int_sel_q <= int_sel_d;
			gnd_q     <= gnd_d;
		end
	end

	assign ext_chan_en_o = ext_en_q;
	assign int_src_sel_o = int_sel_q;
	assign gnd_sel_o     = gnd_q;

	// ************************************************************
	// Shared pin control
	// ************************************************************
	logic [NP-1:0] analog;

	always_comb begin
		for (int i = 0; i < NP; i++) begin
			analog[i] = ({fsel_hi_q[i], fsel_lo_q[i]} ==
				acc_pkg::FSEL_ANALOG);
		end
	end

	assign pin_analog_o = analog;
	assign pin_dig_en_o = ~analog;
	assign pin_pullup_o = pullup_q & ~analog;
	assign pin_drive_o  = dir_q & ~analog;
endmodule

// file: verif/acc_ctrl_properties.sv
// Concurrent checks on the converter control block's ports
`timescale 1ns/10ps
module acc_ctrl_props #(
	parameter int ADDR_W = 8
) (
	input wire logic                         ref_clk_i,
	input wire logic                         nrst_i,
	input wire logic                         ce_i,
	input wire logic                         psel_i,
	input wire logic                         penable_i,
	input wire logic                         pwrite_i,
	input wire logic [ADDR_W-1:0]            paddr_i,
	input wire logic [31:0]                  pwdata_i,
	input wire logic [31:0]                  prdata_o,
	input wire logic                         pready_o,
	input wire logic                         pslverr_o,
	input wire logic                         comp_hi_i,
	input wire logic [acc_pkg::RES_W-1:0]    dac_code_o,
	input wire logic                         sample_o,
	input wire logic                         power_en_o,
	input wire logic [acc_pkg::NUM_PINS-1:0] ext_chan_en_o,
	input wire logic [acc_pkg::NUM_INT-1:0]  int_src_sel_o,
	input wire logic                         gnd_sel_o,
	input wire logic                         conv_done_o,
	input wire logic [acc_pkg::NUM_PINS-1:0] pin_analog_o,
	input wire logic [acc_pkg::NUM_PINS-1:0] pin_dig_en_o,
	input wire logic [acc_pkg::NUM_PINS-1:0] pin_pullup_o,
	input wire logic [acc_pkg::NUM_PINS-1:0] pin_drive_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	// ************************************************************
	// Assertions
	// ************************************************************
	chk_analog_kills_dig: assert property (
		pin_dig_en_o == ~pin_analog_o) else $error("digital path on analog pin");
	chk_pullup_dropped: assert property (
		(pin_pullup_o & pin_analog_o) == '0) else $error("pull-up on analog pin");
	chk_dir_overridden: assert property (
		(pin_drive_o & pin_analog_o) == '0) else $error("analog pin driven");
	chk_ext_single: assert property (
		$onehot0(ext_chan_en_o)) else $error("two external pins joined");
	chk_int_single: assert property (
		$onehot0(int_src_sel_o)) else $error("two internal sources joined");
	chk_gnd_alone: assert property (
		gnd_sel_o |-> int_src_sel_o == '0 && ext_chan_en_o == '0)
		else $error("ground shares the input");
	chk_int_isolates: assert property (
		|int_src_sel_o |-> ext_chan_en_o == '0) else $error("ext pin on internal");
	chk_done_single: assert property (
		conv_done_o |=> !conv_done_o) else $error("done pulse too long");
	chk_unpowered_quiet: assert property (
		!power_en_o && !$past(power_en_o) |-> !sample_o && ext_chan_en_o == '0
		&& int_src_sel_o == '0 && !gnd_sel_o) else $error("active while off");
	chk_sample_stretch: assert property (
		$rose(sample_o) |-> sample_o [*4]) else $error("sampling too short");
	chk_done_after_conv: assert property (
		conv_done_o |-> !sample_o) else $error("done during sampling");

	// ************************************************************
	// Covers
	// ************************************************************
	cov_done: cover property (conv_done_o);
	cov_gnd: cover property (gnd_sel_o);
	cov_int: cover property (|int_src_sel_o);
	cov_err: cover property (pslverr_o);
endmodule

bind acc_ctrl acc_ctrl_props #(.ADDR_W(ADDR_W)) i_props (.*);

// file: verif/acc_analog_model.sv
// Analog sources and comparator behind the converter input
`timescale 1ns/10ps
module acc_analog_model #(
	parameter logic [11:0] AMP_LVL = 12'hc00
) (
	input  wire logic        ref_clk_i,
	input  wire logic [11:0] ext_lvl_i,
	input  wire logic [11:0] dac_code_i,
	input  wire logic        sample_i,
	input  wire logic        power_en_i,
	input  wire logic [7:0]  ext_en_i,
	input  wire logic [5:0]  int_sel_i,
	input  wire logic        gnd_sel_i,
	output logic             comp_hi_o
);
	logic [11:0] lvl;
	logic [11:0] held_q = 12'h000;
	logic        flip_q = 1'b0;

	// Level seen by the converter for the chosen source
	always_comb begin
		lvl = ~held_q;
		if (gnd_sel_i)
			lvl = 12'h000;
		else if (int_sel_i[0])
			lvl = 12'hfff;
		else if (int_sel_i[1])
			lvl = 12'h800;
		else if (int_sel_i[2])
			lvl = 12'h400;
		else if (int_sel_i[3])
			lvl = AMP_LVL;
		else if (int_sel_i[4])
			lvl = AMP_LVL >> 1;
		else if (int_sel_i[5])
			lvl = AMP_LVL >> 2;
		else if (|ext_en_i)
			lvl = ext_lvl_i;
	end

	// Hold taken while sampling; unpowered comparator gives noise
	always_ff @(posedge ref_clk_i) begin
		flip_q <= ~flip_q;
		if (sample_i)
			held_q <= lvl;
	end
	assign comp_hi_o = power_en_i ? (held_q >= dac_code_i) : flip_q;
endmodule

// file: verif/adc_input_and_conversion_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_input_and_conversion_control_tb_top;
	logic        ref_clk_i = 0, nrst_i = 0, ce_i = 1, comp_hi_i;
	logic        psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
	logic [7:0]  paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic [11:0] dac_code_o;
	logic        sample_o, power_en_o, gnd_sel_o, conv_done_o, er;
	logic [7:0]  ext_chan_en_o, pin_analog_o, pin_dig_en_o, pin_pullup_o;
	logic [7:0]  pin_drive_o;
	logic [5:0]  int_src_sel_o;
	int          n_errors = 0, n_compared = 0, s_cnt = 0, t_cnt = 0, t_len;
	// Source, channel, external pins, internal sources, ground
	logic [27:0] rows [16] = '{28'h00_01_00_0, 28'h1b_00_01_0,
		28'h2b_00_02_0, 28'h3b_00_04_0, 28'h4f_80_00_0, 28'h5b_00_08_0,
		28'h6b_00_10_0, 28'h7b_00_20_0, 28'h8b_00_00_1, 28'h90_00_00_1,
		28'hab_00_00_1, 28'hbb_00_00_1, 28'hcb_10_00_0, 28'hd3_00_00_0,
		28'hed_20_00_0, 28'hf4_08_00_0};

	acc_ctrl i_dut (.*);
	acc_analog_model i_model (.ref_clk_i(ref_clk_i), .ext_lvl_i(12'h5a3),
		.dac_code_i(dac_code_o), .sample_i(sample_o),
		.power_en_i(power_en_o), .ext_en_i(ext_chan_en_o),
		.int_sel_i(int_src_sel_o), .gnd_sel_i(gnd_sel_o),
		.comp_hi_o(comp_hi_i));

	initial forever #5 ref_clk_i = ~ref_clk_i;

	// Sampling length and start-to-done span
	always @(posedge ref_clk_i) begin
		if (sample_o)
			s_cnt++;
		if (t_cnt > 0 || sample_o)
			t_cnt++;
		if (conv_done_o) begin
			t_len = t_cnt;
			t_cnt = 0;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel_i <= 1;
		penable_i <= 0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk(0, 1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		@(posedge ref_clk_i);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		chk(rd, exp);
	endtask

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk_i);
		n_errors++;
		conclude();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		int n;
		logic f;
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1;
		@(posedge ref_clk_i);
		chk(pin_dig_en_o, 8'hff);
		chk(power_en_o, 0);
		rdc(acc_pkg::OFS_CTRL_ZERO, 0);
		rdc(acc_pkg::OFS_CTRL_ONE, 0);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			apb(1, acc_pkg::OFS_CTRL_ONE, {24'h0, rows[i][27:24], 4'h0});
			apb(1, acc_pkg::OFS_CTRL_ZERO, {24'h0, 4'h2, rows[i][23:20]});
			@(posedge ref_clk_i);
			chk({12'h0, ext_chan_en_o, 2'b0, int_src_sel_o, 3'b0, gnd_sel_o},
				{12'h0, rows[i][19:0]});
		end
		$display("test routing rows done");
		apb(1, acc_pkg::OFS_FSEL_LOW, 8'h0f);
		apb(1, acc_pkg::OFS_FSEL_HIGH, 8'h05);
		apb(1, acc_pkg::OFS_PULLUP, 8'hff);
		apb(1, acc_pkg::OFS_PORT_DIR, 8'hff);
		chk(pin_analog_o, 8'h05);
		chk(pin_dig_en_o, 8'hfa);
		chk(pin_pullup_o, 8'hfa);
		chk(pin_drive_o, 8'hfa);
		rdc(acc_pkg::OFS_PULLUP, 8'hff);
		apb(1, 8'h20, 8'hff);
		chk(er, 1);
		$display("test pins and bus done");
		apb(1, acc_pkg::OFS_CTRL_ZERO, 8'h20);
		for (int d = 0; d < 8; d++) begin
			f = d[0];
			apb(1, acc_pkg::OFS_CTRL_ONE, d);
			apb(1, acc_pkg::OFS_CTRL_ZERO, {24'h0, 3'h5, f, 4'h0});
			repeat (3) @(posedge ref_clk_i);
			chk(sample_o, 0);
			s_cnt = 0;
			apb(1, acc_pkg::OFS_CTRL_ZERO, {24'h0, 3'h1, f, 4'h0});
			apb(0, acc_pkg::OFS_CTRL_ZERO, 0);
			chk(rd[6], 1);
			n = 0;
			while (rd[6] !== 1'b0 && n < 1000) begin
				apb(0, acc_pkg::OFS_CTRL_ZERO, 0);
				n++;
			end
			chk(rd[6], 0);
			chk(dac_code_o, 12'h5a3);
			chk(conv_done_o, 0);
			chk(s_cnt, 4 << d);
			chk(t_len >= (16 << d) + 1 && t_len <= (16 << d) + 2, 1);
			rdc(acc_pkg::OFS_RES_HIGH, f ? 8'h05 : 8'h5a);
			rdc(acc_pkg::OFS_RES_LOW, f ? 8'ha3 : 8'h30);
		end
		$display("test conversions done");
		// Launch at the slowest divider, then freeze it mid-sampling
		apb(1, acc_pkg::OFS_CTRL_ZERO, 32'hb0);
		apb(1, acc_pkg::OFS_CTRL_ZERO, 32'h30);
		ce_i <= 0;
		repeat (600) @(posedge ref_clk_i);
		chk(sample_o, 1);
		chk(pready_o, 0);
		ce_i <= 1;
		$display("test clock enable done");
		// Power off aborts; format kept so the result reads as before
		apb(1, acc_pkg::OFS_CTRL_ZERO, 32'h10);
		apb(1, acc_pkg::OFS_RES_HIGH, 8'hff);
		rdc(acc_pkg::OFS_RES_HIGH, 8'h05);
		rdc(acc_pkg::OFS_RES_LOW, 8'ha3);
		chk(power_en_o, 0);
		$display("test power off done");
		conclude();
	end
endmodule
